// ==== core/spcfg_consts.svh ====
// constants and field layout of the serial port configuration bank
// Function
// - a write to the configuration register takes effect at once, no update command
// - bit 4 selects long instruction, resets to 1; host keeps it set
// - writing bit 5 as 1 restores every other register to default
// - soft reset bit stays set until the host writes 0 to it
// - bit 6 set: data shifts LSB first and address increments per byte
// - bit 6 clear (reset): data shifts MSB first and address decrements
// - bit 7 set: serial out pin floats, read data goes on the data pin
// - bit 7 clear (reset): read data driven on the serial out pin
`ifndef SPCFG_CONSTS_SVH
`define SPCFG_CONSTS_SVH

// =====================================================
// register map
`define SPCFG_ADDR_W 13
`define SPCFG_OFS_CONFIG 13'h0000
`define SPCFG_OFS_UNUSED1 13'h0001
`define SPCFG_OFS_UNUSED2 13'h0002
`define SPCFG_OFS_UNUSED3 13'h0003
`define SPCFG_OFS_SWALLOW 13'h0004

// =====================================================
// configuration fields
`define SPCFG_BIT_LONG 4
`define SPCFG_BIT_SOFTRST 5
`define SPCFG_BIT_LSBFIRST 6
`define SPCFG_BIT_BIDIR 7
`define SPCFG_CFG_MASK 8'hf0
`define SPCFG_CFG_RESET 8'h10
`define SPCFG_SWALLOW_W 6
`define SPCFG_SWALLOW_RESET 6'h00

// =====================================================
// frame timing in link clock edges and the streaming byte count code
`define SPCFG_LONG_LAST 4'hf
`define SPCFG_SHORT_LAST 4'h7
`define SPCFG_BYTE_LAST 4'h7
`define SPCFG_STREAM 2'h3

`endif

// ==== core/spcfg_pkg.sv ====
// types shared by the serial port configuration bank
package spcfg_pkg;
    typedef enum logic [1:0] {
        PH_INSTR = 2'b00,
        PH_DATA = 2'b01,
        PH_DONE = 2'b10
    } phase_t;
endpackage

// ==== core/spcfg_link_if.sv ====
// carrier between the link-side engine and the register file
`timescale 1ns/1ps
`include "spcfg_consts.svh"
interface spcfg_link_if;
    logic wrToggle;
    logic wrToggleSync;
    logic [`SPCFG_ADDR_W-1:0] wrAddr;
    logic [7:0] wrData;
    logic ackToggle;
    logic [7:0] cfgByte;
    logic [`SPCFG_SWALLOW_W-1:0] swallow;
    modport engine (
        output wrToggle, wrAddr, wrData,
        input ackToggle, cfgByte, swallow
    );
    modport regs (
        input wrToggleSync, wrAddr, wrData,
        output ackToggle, cfgByte, swallow
    );
endinterface

// ==== core/sync_2ff.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] metaQ;
    logic [WIDTH-1:0] syncQ;

    // =====================================================
    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            metaQ <= '0;
            syncQ <= '0;
        end else begin
            metaQ <= din;
            syncQ <= metaQ;
        end
    end

    assign dout = syncQ;
endmodule

// ==== core/spcfg_reg_file.sv ====
// register storage on the reference clock
`timescale 1ns/1ps
`include "spcfg_consts.svh"
module spcfg_reg_file #(
    parameter logic [`SPCFG_SWALLOW_W-1:0] SWALLOW_DEFAULT = `SPCFG_SWALLOW_RESET
) (
    input wire logic clk,
    input wire logic rst,
    spcfg_link_if.regs link
);
    logic seenQ, seenD;
    logic [7:0] cfgQ, cfgD;
    logic [`SPCFG_SWALLOW_W-1:0] swQ, swD;
    logic applyWr;

    // =====================================================
    // apply writes handed over by the link side
    always_comb begin
        applyWr = link.wrToggleSync != seenQ;
        seenD = link.wrToggleSync;
        cfgD = cfgQ;
        swD = swQ;
        if (applyWr && link.wrAddr == `SPCFG_OFS_CONFIG) begin
            cfgD = link.wrData & `SPCFG_CFG_MASK;
        end
        if (applyWr && link.wrAddr == `SPCFG_OFS_SWALLOW) begin
            swD = link.wrData[`SPCFG_SWALLOW_W-1:0];
        end
        // soft reset holds every other register at default
        if (cfgQ[`SPCFG_BIT_SOFTRST]) begin
            swD = SWALLOW_DEFAULT;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            seenQ <= 1'b0;
            cfgQ <= `SPCFG_CFG_RESET;
            swQ <= SWALLOW_DEFAULT;
        end else begin
            seenQ <= seenD;
            cfgQ <= cfgD;
            swQ <= swD;
        end
    end

    assign link.ackToggle = seenQ;
    assign link.cfgByte = cfgQ;
    assign link.swallow = swQ;

    // =====================================================
    // checks on the register file
    cfg_apply_a: assert property (@(posedge clk) disable iff (rst)
        (applyWr && link.wrAddr == `SPCFG_OFS_CONFIG)
        |=> (cfgQ == ($past(link.wrData) & `SPCFG_CFG_MASK)) && (seenQ != $past(seenQ)))
        else $error("config write not applied on the next edge");
    long_reset_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> cfgQ == `SPCFG_CFG_RESET)
        else $error("config register left reset with wrong value");
    soft_hold_a: assert property (@(posedge clk) disable iff (rst)
        cfgQ[`SPCFG_BIT_SOFTRST] |=> swQ == SWALLOW_DEFAULT)
        else $error("counter not held at default during soft reset");
    soft_sticky_a: assert property (@(posedge clk) disable iff (rst)
        (cfgQ[`SPCFG_BIT_SOFTRST] && !(applyWr && link.wrAddr == `SPCFG_OFS_CONFIG))
        |=> cfgQ[`SPCFG_BIT_SOFTRST])
        else $error("soft reset bit cleared itself");
    unused_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (applyWr && link.wrAddr != `SPCFG_OFS_CONFIG && link.wrAddr != `SPCFG_OFS_SWALLOW)
        |=> $stable(cfgQ) && (cfgQ[3:0] == 4'h0))
        else $error("write to unused address changed state");
endmodule

// ==== core/serial_port_config_regs.sv ====
// serial link engine with its configuration register and first counter field
`timescale 1ns/1ps
`include "spcfg_consts.svh"
module serial_port_config_regs #(
    parameter logic [`SPCFG_SWALLOW_W-1:0] SWALLOW_DEFAULT = `SPCFG_SWALLOW_RESET
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic csbN,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOeN,
    output logic serialOut,
    output logic serialOutOeN,
    output logic longInstr,
    output logic softReset,
    output logic lsbFirst,
    output logic bidirMode,
    output logic [`SPCFG_SWALLOW_W-1:0] swallowCount
);
    spcfg_link_if link();

    // frame state on the link clock
    spcfg_pkg::phase_t phaseQ, phaseD;
    logic [3:0] bitCntQ, bitCntD;
    logic [15:0] shiftQ, shiftD;
    logic isReadQ, isReadD;
    logic [`SPCFG_ADDR_W-1:0] addrQ, addrD;
    logic [1:0] bytesLeftQ, bytesLeftD;
    logic streamQ, streamD;
    logic fireWr;
    logic [7:0] rxByte;
    logic [15:0] instrWord;
    logic [3:0] instrLast;

    // write handover on the link clock
    logic wrToggleQ, wrToggleD;
    logic [`SPCFG_ADDR_W-1:0] wrAddrQ, wrAddrD;
    logic [7:0] wrDataQ, wrDataD;

    // acknowledge sync and readback snapshot on the link clock
    logic ackMetaQ, ackSyncQ;
    logic [7:0] cfgSnapQ, cfgSnapD;
    logic [`SPCFG_SWALLOW_W-1:0] swSnapQ, swSnapD;
    logic lsbSclk, longSclk, bidirSclk;

    // output stage on the falling link clock edge
    logic outBitQ, outBitD;
    logic sdioOeNQ, sdioOeND;
    logic serOeNQ, serOeND;
    logic [7:0] rdByte;
    logic driveRead;

    // =====================================================
    // helper functions

    // reverse the bit order of one byte
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    // read value of one register address, unmapped space reads zero
    function automatic logic [7:0] regByte(
        input logic [`SPCFG_ADDR_W-1:0] a,
        input logic [7:0] cfg,
        input logic [`SPCFG_SWALLOW_W-1:0] sw
    );
        logic [7:0] r;
        r = 8'h00;
        if (a == `SPCFG_OFS_CONFIG) begin
            r = cfg;
        end else if (a == `SPCFG_OFS_SWALLOW) begin
            r = {2'h0, sw};
        end
        return r;
    endfunction

    // =====================================================
    // mode bits seen by the link logic
    assign lsbSclk = cfgSnapQ[`SPCFG_BIT_LSBFIRST];
    assign longSclk = cfgSnapQ[`SPCFG_BIT_LONG];
    assign bidirSclk = cfgSnapQ[`SPCFG_BIT_BIDIR];

    // =====================================================
    // instruction and data shifting, next state
    always_comb begin
        phaseD = phaseQ;
        bitCntD = bitCntQ + 4'h1;
        shiftD = {shiftQ[14:0], sdioIn};
        isReadD = isReadQ;
        addrD = addrQ;
        bytesLeftD = bytesLeftQ;
        streamD = streamQ;
        fireWr = 1'b0;
        instrLast = longSclk ? `SPCFG_LONG_LAST : `SPCFG_SHORT_LAST;
        // bits arrive in link order, put them back in word order
        rxByte = lsbSclk ? rev8(shiftD[7:0]) : shiftD[7:0];
        if (longSclk) begin
            instrWord = lsbSclk ? {rev8(shiftD[7:0]), rev8(shiftD[15:8])} : shiftD;
        end else begin
            instrWord = {8'h00, rxByte};
        end
        unique case (phaseQ)
            spcfg_pkg::PH_INSTR: begin
                if (bitCntQ == instrLast) begin
                    phaseD = spcfg_pkg::PH_DATA;
                    bitCntD = 4'h0;
                    if (longSclk) begin
                        isReadD = instrWord[15];
                        bytesLeftD = instrWord[14:13];
                        addrD = instrWord[12:0];
                    end else begin
                        isReadD = instrWord[7];
                        bytesLeftD = instrWord[6:5];
                        addrD = {8'h00, instrWord[4:0]};
                    end
                    streamD = bytesLeftD == `SPCFG_STREAM;
                end
            end
            spcfg_pkg::PH_DATA: begin
                if (bitCntQ == `SPCFG_BYTE_LAST) begin
                    bitCntD = 4'h0;
                    fireWr = !isReadQ;
                    // step the address between bytes
                    addrD = lsbSclk ? addrQ + 13'h1 : addrQ - 13'h1;
                    if (!streamQ) begin
                        if (bytesLeftQ == 2'h0) begin
                            phaseD = spcfg_pkg::PH_DONE;
                        end else begin
                            bytesLeftD = bytesLeftQ - 2'h1;
                        end
                    end
                end
            end
            spcfg_pkg::PH_DONE: begin
                bitCntD = bitCntQ;
            end
            default: begin
                phaseD = spcfg_pkg::PH_DONE;
            end
        endcase
    end

    // frame state clears whenever chip select is released
    always_ff @(posedge sclk or posedge csbN) begin
        if (csbN) begin
            phaseQ <= spcfg_pkg::PH_INSTR;
            bitCntQ <= 4'h0;
            shiftQ <= 16'h0000;
            isReadQ <= 1'b0;
            addrQ <= 13'h0000;
            bytesLeftQ <= 2'h0;
            streamQ <= 1'b0;
        end else begin
            phaseQ <= phaseD;
            bitCntQ <= bitCntD;
            shiftQ <= shiftD;
            isReadQ <= isReadD;
            addrQ <= addrD;
            bytesLeftQ <= bytesLeftD;
            streamQ <= streamD;
        end
    end

    // =====================================================
    // write handover: toggle with address and data held until the next write byte fires, with no wait for the acknowledge
    always_comb begin
        wrToggleD = wrToggleQ;
        wrAddrD = wrAddrQ;
        wrDataD = wrDataQ;
        if (fireWr) begin
            wrToggleD = !wrToggleQ;
            wrAddrD = addrQ;
            wrDataD = rxByte;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            wrToggleQ <= 1'b0;
            wrAddrQ <= 13'h0000;
            wrDataQ <= 8'h00;
        end else begin
            wrToggleQ <= wrToggleD;
            wrAddrQ <= wrAddrD;
            wrDataQ <= wrDataD;
        end
    end

    assign link.wrToggle = wrToggleQ;
    assign link.wrAddr = wrAddrQ;
    assign link.wrData = wrDataQ;

    // =====================================================
    // register values are only sampled while no write is in flight
    always_comb begin
        cfgSnapD = cfgSnapQ;
        swSnapD = swSnapQ;
        if (wrToggleQ == ackSyncQ) begin
            cfgSnapD = link.cfgByte;
            swSnapD = link.swallow;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            ackMetaQ <= 1'b0;
            ackSyncQ <= 1'b0;
            cfgSnapQ <= `SPCFG_CFG_RESET;
            swSnapQ <= SWALLOW_DEFAULT;
        end else begin
            ackMetaQ <= link.ackToggle;
            ackSyncQ <= ackMetaQ;
            cfgSnapQ <= cfgSnapD;
            swSnapQ <= swSnapD;
        end
    end

    // =====================================================
    // read data and pin enables, launched on the falling edge
    always_comb begin
        rdByte = regByte(addrQ, cfgSnapQ, swSnapQ);
        driveRead = (phaseQ == spcfg_pkg::PH_DATA) && isReadQ;
        outBitD = rdByte[lsbSclk ? bitCntQ[2:0] : 3'h7 - bitCntQ[2:0]];
        sdioOeND = !(driveRead && bidirSclk);
        serOeND = !(driveRead && !bidirSclk);
    end

    always_ff @(negedge sclk or posedge csbN) begin
        if (csbN) begin
            outBitQ <= 1'b0;
            sdioOeNQ <= 1'b1;
            serOeNQ <= 1'b1;
        end else begin
            outBitQ <= outBitD;
            sdioOeNQ <= sdioOeND;
            serOeNQ <= serOeND;
        end
    end

    assign sdioOut = outBitQ;
    assign serialOut = outBitQ;
    assign sdioOeN = sdioOeNQ;
    assign serialOutOeN = serOeNQ;

    // =====================================================
    // reference clock side
    sync_2ff #(.WIDTH(1)) wrSyncU (
        .clk(ref_clk),
        .rst(rst),
        .din(link.wrToggle),
        .dout(link.wrToggleSync)
    );

    spcfg_reg_file #(.SWALLOW_DEFAULT(SWALLOW_DEFAULT)) regsU (
        .clk(ref_clk),
        .rst(rst),
        .link(link)
    );

    assign longInstr = link.cfgByte[`SPCFG_BIT_LONG];
    assign softReset = link.cfgByte[`SPCFG_BIT_SOFTRST];
    assign lsbFirst = link.cfgByte[`SPCFG_BIT_LSBFIRST];
    assign bidirMode = link.cfgByte[`SPCFG_BIT_BIDIR];
    assign swallowCount = link.swallow;

    // =====================================================
    // checks on the link side
    instr_len_a: assert property (@(posedge sclk) disable iff (csbN)
        (phaseQ == spcfg_pkg::PH_INSTR && bitCntQ == `SPCFG_SHORT_LAST)
        |=> (phaseQ == spcfg_pkg::PH_INSTR) == $past(longSclk))
        else $error("instruction phase length does not follow the mode bit");
    addr_step_a: assert property (@(posedge sclk) disable iff (csbN)
        (phaseQ == spcfg_pkg::PH_DATA && bitCntQ == `SPCFG_BYTE_LAST)
        |=> addrQ == ($past(lsbSclk) ? $past(addrQ) + 13'h1 : $past(addrQ) - 13'h1))
        else $error("address did not step in the selected direction");
    lsb_first_a: assert property (@(negedge sclk) disable iff (csbN)
        (driveRead && lsbSclk && bitCntQ == 4'h0) |=> outBitQ == $past(rdByte[0]))
        else $error("first read bit is not the least significant");
    msb_first_a: assert property (@(negedge sclk) disable iff (csbN)
        (driveRead && !lsbSclk && bitCntQ == 4'h0) |=> outBitQ == $past(rdByte[7]))
        else $error("first read bit is not the most significant");
    bidir_float_a: assert property (@(negedge sclk) disable iff (csbN)
        (driveRead && bidirSclk) |=> serialOutOeN && !sdioOeN)
        else $error("bidirectional read not steered to the data pin");
    uni_drive_a: assert property (@(negedge sclk) disable iff (csbN)
        (driveRead && !bidirSclk) |=> !serialOutOeN && sdioOeN)
        else $error("unidirectional read not on the serial out pin");
    sdio_release_a: assert property (@(negedge sclk) disable iff (csbN)
        !driveRead |=> sdioOeN && serialOutOeN)
        else $error("data pin driven outside a read data phase");
endmodule

// ==== verif/serial_host_model.sv ====
// host controller model that drives the serial link frames
`timescale 1ns/1ps
module serial_host_model (
    output logic sclk,
    output logic csbN,
    output logic sdio,
    input wire logic sdioOut,
    input wire logic sdioOeN,
    input wire logic serialOut,
    input wire logic serialOutOeN
);
    logic hostBit;
    logic hostOe;
    logic idleBit;
    logic expectIdle;
    int badDrive;

    // ==========================================
    // data pin level
    // device wins, then host, else a pattern that flips every bit period
    assign sdio = !sdioOeN ? sdioOut : (hostOe ? hostBit : idleBit);

    initial begin
        sclk = 1'b0;
        csbN = 1'b1;
        hostBit = 1'b0;
        hostOe = 1'b0;
        idleBit = 1'b1;
        expectIdle = 1'b0;
        badDrive = 0;
    end

    // ==========================================
    // bit and frame tasks
    // one sclk period: bit set while low, pins sampled just before the rise
    task automatic clk_bit(input logic b, output logic s, output logic viaBidir);
        hostBit = b;
        idleBit = ~idleBit;
        #3;
        if (hostOe && !sdioOeN) badDrive++;
        if (!sdioOeN && !serialOutOeN) badDrive++;
        if (expectIdle && (!sdioOeN || !serialOutOeN)) badDrive++;
        viaBidir = !sdioOeN;
        s = !serialOutOeN ? serialOut : sdio;
        sclk = 1'b1;
        #3;
        sclk = 1'b0;
    endtask

    // one whole frame; bytes sit at wd/rdq[8k+:8], k in transfer order
    task automatic frame(input logic rd, input int nb, input logic [12:0] addr,
                         input logic lsb, input logic [31:0] wd,
                         output logic [31:0] rdq, output logic bidirSeen);
        logic [15:0] ins;
        logic s;
        logic v;
        ins = {rd, 2'(nb - 1), addr};
        rdq = '0;
        bidirSeen = 1'b0;
        csbN = 1'b0;
        hostOe = 1'b1;
        #3;
        // whole word reversed when least significant bit goes first
        for (int i = 0; i < 16; i++) begin
            clk_bit(lsb ? ins[i] : ins[15 - i], s, v);
        end
        hostOe = !rd;
        for (int k = 0; k < nb; k++) begin
            for (int i = 0; i < 8; i++) begin
                int j;
                j = lsb ? i : 7 - i;
                clk_bit(wd[8 * k + j], s, v);
                rdq[8 * k + j] = s;
                if (rd) bidirSeen |= v;
            end
        end
        // spare clocks let the link side pick up a new mode before the next frame
        hostOe = 1'b0;
        expectIdle = 1'b1;
        for (int i = 0; i < 4; i++) begin
            clk_bit(1'b0, s, v);
        end
        expectIdle = 1'b0;
        #3;
        csbN = 1'b1;
        #6;
    endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the serial port configuration bank
`timescale 1ns/1ps
`include "spcfg_consts.svh"
module tb_top;
    localparam logic [`SPCFG_SWALLOW_W-1:0] SW_DEF = 6'h15;
    logic ref_clk;
    logic rst;
    logic sclk;
    logic csbN;
    logic sdio;
    logic sdioOut;
    logic sdioOeN;
    logic serialOut;
    logic serialOutOeN;
    logic longInstr;
    logic softReset;
    logic lsbFirst;
    logic bidirMode;
    logic [`SPCFG_SWALLOW_W-1:0] swallowCount;
    logic [3:0] cfg;
    logic [31:0] rdq;
    logic bd;
    int n_fail;
    int samples_checked;
    int cycles;

    assign cfg = {bidirMode, lsbFirst, softReset, longInstr};

    serial_port_config_regs #(.SWALLOW_DEFAULT(SW_DEF)) dut (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .csbN(csbN), .sdioIn(sdio),
        .sdioOut(sdioOut), .sdioOeN(sdioOeN), .serialOut(serialOut),
        .serialOutOeN(serialOutOeN), .longInstr(longInstr), .softReset(softReset),
        .lsbFirst(lsbFirst), .bidirMode(bidirMode), .swallowCount(swallowCount)
    );

    serial_host_model host (
        .sclk(sclk), .csbN(csbN), .sdio(sdio), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
        .serialOut(serialOut), .serialOutOeN(serialOutOeN)
    );

    // ==========================================
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ==========================================
    // compare, access and closing tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    // write one byte, then give the register clock time to apply it
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
        host.frame(1'b0, 1, a, lsb, {24'h000000, d}, rdq, bd);
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [12:0] a, input int nb, input logic lsb);
        host.frame(1'b1, nb, a, lsb, 32'h00000000, rdq, bd);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================
    // test sequence
    initial begin
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        rst = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        // defaults and plain reads
        check("cfg reset", cfg, 4'h1);
        check("count reset", swallowCount, SW_DEF);
        rd(13'h0000, 1, 1'b0);
        check("read cfg", rdq[7:0], 8'h10);
        check("unidir pin", bd, 1'b0);
        rd(13'h0001, 2, 1'b0);
        check("read down", rdq[15:0], 16'h1000);
        // immediate writes, unused bits and addresses
        wr(13'h0004, 8'hff, 1'b0);
        check("count write", swallowCount, 6'h3f);
        rd(13'h0004, 1, 1'b0);
        check("read count", rdq[7:0], 8'h3f);
        wr(13'h0002, 8'h5a, 1'b0);
        rd(13'h0002, 1, 1'b0);
        check("read unused", rdq[7:0], 8'h00);
        wr(13'h0000, 8'h1f, 1'b0);
        check("cfg low bits", cfg, 4'h1);
        rd(13'h0000, 1, 1'b0);
        check("read cfg low", rdq[7:0], 8'h10);
        // least significant bit first, addresses step upward
        wr(13'h0000, 8'h50, 1'b0);
        check("cfg lsb", cfg, 4'h5);
        rd(13'h0003, 2, 1'b1);
        check("read up", rdq[15:0], 16'h3f00);
        wr(13'h0004, 8'h2c, 1'b1);
        check("count lsb", swallowCount, 6'h2c);
        wr(13'h0000, 8'h10, 1'b1);
        check("cfg msb", cfg, 4'h1);
        // soft reset holds until the host clears it
        wr(13'h0004, 8'h2a, 1'b0);
        wr(13'h0000, 8'h30, 1'b0);
        check("count soft", swallowCount, SW_DEF);
        wr(13'h0004, 8'h01, 1'b0);
        repeat (20) @(posedge ref_clk);
        #1;
        check("soft held", softReset, 1'b1);
        check("count held", swallowCount, SW_DEF);
        rd(13'h0000, 1, 1'b0);
        check("cfg kept", rdq[7:0], 8'h30);
        wr(13'h0000, 8'h10, 1'b0);
        wr(13'h0004, 8'h01, 1'b0);
        check("count after", swallowCount, 6'h01);
        // shared data pin mode and back
        wr(13'h0000, 8'h90, 1'b0);
        check("cfg bidir", cfg, 4'h9);
        rd(13'h0004, 1, 1'b0);
        check("read bidir", rdq[7:0], 8'h01);
        check("bidir pin", bd, 1'b1);
        wr(13'h0000, 8'h10, 1'b0);
        rd(13'h0000, 1, 1'b0);
        check("read unidir", rdq[7:0], 8'h10);
        check("unidir pin back", bd, 1'b0);
        // streamed write walks downward from 0x5 until chip select rises
        host.frame(1'b0, 4, 13'h0005, 1'b0, 32'h00002b00, rdq, bd);
        repeat (8) @(posedge ref_clk);
        #1;
        check("count stream", swallowCount, 6'h2b);
        check("pin clash", 16'(host.badDrive), 16'h0000);
        report_and_stop();
    end
endmodule
